// File: tlc_core.sv
// Control core of the three-level 8-bit processor.
`timescale 1ns/1ps
`include "tlc_regs.svh"
// What this block does
// - 32K space of 4K blocks, 256-word pages.
// - Upper address byte on output bus.
// - Low bus: address, write data, reads.
// - Each level owns PC, accumulator, link.
// - Enabled middle interrupt moves level 3 to 2.
// - High interrupt selects level one first.
// - Two indicators report the active level.
// - Calls push return pair in page zero.
// - Stack pointer marks next free slot.
// - Direct address on current page or zero.
// - Indirect addresses chain while top bit set.
// - Format one: page and indirect bits.
// - Format two: 12-bit address, own block.
// - Format three: second byte is immediate.
// - Single-byte full-opcode instructions.
// - I/O opcode top four bits only.
// - Accumulator/link: five-bit variant field.
// - Enable bits: bit0 high, bit1 middle.
// - Strobe one presents code and accumulator.
// - Strobe three captures peripheral data.
// - Strobe four ends the transfer.
module tlc_core #(
  parameter int ADDR_BITS = 15
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       wait_req,
  input  wire logic       high_priority_irq,
  input  wire logic       middle_priority_irq,
  input  wire logic [7:0] lower_shared_bus_in,
  output logic      [7:0] lower_shared_bus_out,
  output logic            lower_shared_bus_oe,
  output logic      [7:0] upper_address_bus,
  output logic            addr_strobe,
  output logic            mem_read,
  output logic            mem_write,
  output logic      [3:0] io_strobe,
  output logic            io_input,
  output logic            dma_ready,
  output logic            level_one_indicator,
  output logic            level_two_indicator
);
  import tlc_pkg::*;

  localparam logic [15:0] AMASK = 16'((32'h1 << ADDR_BITS) - 1);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (ADDR_BITS < 9 || ADDR_BITS > 15) begin : g_bad
    $error("ADDR_BITS must lie between 9 and 15.");
  end

  tlc_state_t  st_q, st_d;
  tlc_level_t  lvl_q, lvl_d, prev_q, prev_d;
  logic        ph_q, ph_d, en1_q, en1_d, en2_q, en2_d, aux_q, aux_d;
  logic [15:0] mar_q, mar_d, ea_q, ea_d, ia_q, ia_d, full;
  logic [7:0]  ir_q, ir_d, wdat_q, wdat_d, sp_q, sp_d, ptr_q, ptr_d;
  logic [1:0]  cnt_q, cnt_d;
  logic        done, jump, call, mem_d, wr_d;
  logic [3:0]  sub;
  logic [8:0]  add9;
  logic [4:0]  nib;
  tlc_ctx_t    ctx_q [3];
  tlc_ctx_t    cur, ctx_n;
  logic        ctx_we;
  tlc_dec_t    dec;
  tlc_bus_t    bus_q, bus_d;

  // ---------------------------------------------------------------
  // Banked contexts and decoder
  // ---------------------------------------------------------------
  // One context per level; only the active level is written.
  for (genvar g = 0; g < 3; g++) begin : g_bank
    tlc_ctx_bank u_bank (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .we      (ctx_we && lvl_q == tlc_level_t'(g)),
      .d       (ctx_n),
      .q       (ctx_q[g])
    );
  end

  // Decode the byte arriving in fetch, else the held instruction.
  tlc_decode u_dec (
    .ir  ((st_q == S_FETCH) ? lower_shared_bus_in : ir_q),
    .dec (dec)
  );

  // True for states that run a memory cycle.
  function automatic logic is_mem(tlc_state_t s);
    return s inside {S_FETCH, S_OPND2, S_IPTR_HI, S_IPTR_LO, S_RD, S_WR,
                     S_PUSH_HI, S_PUSH_LO, S_POP_HI, S_POP_LO};
  endfunction

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Next state, addresses, context and bus image.
  always_comb begin
    st_d = st_q;  lvl_d = lvl_q;  prev_d = prev_q;  ph_d = ph_q;
    en1_d = en1_q;  en2_d = en2_q;  aux_d = aux_q;  mar_d = mar_q;
    ea_d = ea_q;  ia_d = ia_q;  ir_d = ir_q;  wdat_d = wdat_q;
    sp_d = sp_q;  ptr_d = ptr_q;  cnt_d = cnt_q;
    cur = ctx_q[lvl_q];
    ctx_n = cur;
    ctx_we = 1'b0;
    full = {ptr_q, lower_shared_bus_in};
    sub = ir_q[5:2];
    jump = (dec.fmt == F_MEM) ? (sub == `TLC_F1_JMP)
                              : (ir_q[7:4] == `TLC_F2_JMP);
    call = (dec.fmt == F_MEM) ? (sub == `TLC_F1_CALL)
                              : (ir_q[7:4] == `TLC_F2_CALL);
    add9 = {1'b0, cur.acc} + {1'b0, lower_shared_bus_in};
    nib = {1'b0, cur.acc[3:0]} + {1'b0, lower_shared_bus_in[3:0]};
    // A memory state spends one address phase, then waits in data.
    done = is_mem(st_q) && ph_q && !wait_req;
    if (is_mem(st_q) && !ph_q) begin
      ph_d = 1'b1;
    end
    case (st_q)
      S_BOUND: begin
        if (!wait_req) begin
          if (high_priority_irq && en1_q && lvl_q != LV1) begin
            prev_d = lvl_q;
            lvl_d = LV1;
          end else if (middle_priority_irq && en2_q && lvl_q == LV3) begin
            lvl_d = LV2;
          end
          st_d = S_FETCH;
          ph_d = 1'b0;
          mar_d = ctx_q[lvl_d].pc & AMASK;
          ia_d = ctx_q[lvl_d].pc;
        end
      end
      S_FETCH: begin
        if (done) begin
          ir_d = lower_shared_bus_in;
          ctx_n.pc = cur.pc + 16'h0001;
          ctx_we = 1'b1;
          ph_d = 1'b0;
          cnt_d = 2'h0;
          if (dec.fmt inside {F_MEM, F_LONG, F_IMM}) begin
            st_d = S_OPND2;
            mar_d = ctx_n.pc & AMASK;
          end else if (dec.fmt == F_IO) begin
            st_d = S_IO;
          end else begin
            st_d = S_EXEC;
          end
        end
      end
      S_OPND2: begin
        if (done) begin
          ctx_n.pc = cur.pc + 16'h0001;
          ctx_we = 1'b1;
          ph_d = 1'b0;
          st_d = S_EXEC;
          if (dec.fmt == F_IMM) begin
            st_d = S_BOUND;
            if (ir_q[3:0] == `TLC_F3_LDI) begin
              ctx_n.acc = lower_shared_bus_in;
            end else begin
              {ctx_n.link, ctx_n.acc} = add9;
              aux_d = (lvl_q == LV3) ? nib[4] : aux_q;
            end
          end else if (dec.fmt == F_LONG) begin
            ea_d = {ia_q[15:12], ir_q[3:0], lower_shared_bus_in};
          end else begin
            // Page bit picks the instruction's page or page zero.
            ea_d = {dec.cur_page ? ia_q[15:8] : 8'h00,
                    lower_shared_bus_in};
            if (dec.ind) begin
              st_d = S_IPTR_HI;
              mar_d = ea_d & AMASK;
            end
          end
        end
      end
      S_IPTR_HI: begin
        if (done) begin
          ptr_d = lower_shared_bus_in;
          mar_d = (mar_q + 16'h0001) & AMASK;
          ph_d = 1'b0;
          st_d = S_IPTR_LO;
        end
      end
      S_IPTR_LO: begin
        if (done) begin
          ph_d = 1'b0;
          if (full[15]) begin
            st_d = S_IPTR_HI;
            mar_d = full & AMASK;
          end else begin
            ea_d = full;
            st_d = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        st_d = S_BOUND;
        ph_d = 1'b0;
        case (dec.fmt)
          F_MEM, F_LONG: begin
            if (jump) begin
              ctx_n.pc = ea_d & AMASK;
              ctx_we = 1'b1;
            end else if (call) begin
              st_d = S_PUSH_HI;
              mar_d = {`TLC_STACK_PAGE, sp_q};
              wdat_d = cur.pc[15:8];
            end else if (sub == `TLC_F1_STA) begin
              st_d = S_WR;
              mar_d = ea_q & AMASK;
              wdat_d = cur.acc;
            end else begin
              st_d = S_RD;
              mar_d = ea_q & AMASK;
            end
          end
          F_ONE: begin
            ctx_we = 1'b1;
            case (ir_q)
              `TLC_OP_RET: begin
                st_d = S_POP_HI;
                sp_d = sp_q - `TLC_SP_STEP;
                mar_d = {`TLC_STACK_PAGE, sp_d};
              end
              `TLC_OP_ROT: {ctx_n.link, ctx_n.acc} = {cur.acc, cur.link};
              `TLC_OP_SWAP: ctx_n.acc = {cur.acc[3:0], cur.acc[7:4]};
              `TLC_OP_SKZ: begin
                if (cur.acc == 8'h00) begin
                  ctx_n.pc = cur.pc + 16'h0001;
                end
              end
              `TLC_OP_RETI: begin
                if (lvl_q == LV1) begin
                  lvl_d = prev_q;
                end else if (lvl_q == LV2) begin
                  lvl_d = LV3;
                end
              end
              default: ctx_we = 1'b0;
            endcase
          end
          F_ACCL: begin
            ctx_we = 1'b1;
            case (ir_q[4:0])
              `TLC_AL_CLA: ctx_n.acc = 8'h00;
              `TLC_AL_CMA: ctx_n.acc = ~cur.acc;
              `TLC_AL_CLL: ctx_n.link = 1'b0;
              `TLC_AL_CML: ctx_n.link = ~cur.link;
              `TLC_AL_INC: begin
                {ctx_n.link, ctx_n.acc} = {1'b0, cur.acc} + 9'h001;
                aux_d = (lvl_q == LV3) ? (cur.acc[3:0] == 4'hf) : aux_q;
              end
              default: ctx_we = 1'b0;
            endcase
          end
          F_IRQ: begin
            // Bit zero names the high interrupt, bit one the middle.
            if (ir_q[0]) begin
              en1_d = (ir_q[7:2] == `TLC_F7_ON);
            end
            if (ir_q[1]) begin
              en2_d = (ir_q[7:2] == `TLC_F7_ON);
            end
          end
          default: st_d = S_BOUND;
        endcase
      end
      S_RD: begin
        if (done) begin
          st_d = S_BOUND;
          ctx_we = 1'b1;
          if (sub == `TLC_F1_LDA) begin
            ctx_n.acc = lower_shared_bus_in;
          end else if (sub == `TLC_F1_ADD) begin
            {ctx_n.link, ctx_n.acc} = add9;
            aux_d = (lvl_q == LV3) ? nib[4] : aux_q;
          end else if (sub == `TLC_F1_AND) begin
            ctx_n.acc = cur.acc & lower_shared_bus_in;
          end
        end
      end
      S_WR: begin
        if (done) begin
          st_d = S_BOUND;
        end
      end
      S_PUSH_HI: begin
        if (done) begin
          st_d = S_PUSH_LO;
          ph_d = 1'b0;
          mar_d = {`TLC_STACK_PAGE, sp_q + 8'h01};
          wdat_d = cur.pc[7:0];
        end
      end
      S_PUSH_LO: begin
        if (done) begin
          st_d = S_BOUND;
          sp_d = sp_q + `TLC_SP_STEP;
          ctx_n.pc = ea_q & AMASK;
          ctx_we = 1'b1;
        end
      end
      S_POP_HI: begin
        if (done) begin
          st_d = S_POP_LO;
          ph_d = 1'b0;
          ptr_d = lower_shared_bus_in;
          mar_d = {`TLC_STACK_PAGE, sp_q + 8'h01};
        end
      end
      S_POP_LO: begin
        if (done) begin
          st_d = S_BOUND;
          ctx_n.pc = full & AMASK;
          ctx_we = 1'b1;
        end
      end
      S_IO: begin
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == `TLC_IO_CAPTURE && dec.io_in) begin
          ctx_n.acc = lower_shared_bus_in;
          ctx_we = 1'b1;
        end
        if (cnt_q == `TLC_IO_LAST) begin
          st_d = S_BOUND;
        end
      end
      default: st_d = S_BOUND;
    endcase

    // Bus image of the next cycle, registered below.
    mem_d = is_mem(st_d);
    wr_d = st_d inside {S_WR, S_PUSH_HI, S_PUSH_LO};
    bus_d = '0;
    bus_d.uab = mem_d ? mar_d[15:8] : 8'h00;
    bus_d.ale = mem_d && !ph_d;
    bus_d.rd = mem_d && ph_d && !wr_d;
    bus_d.wr = mem_d && ph_d && wr_d;
    bus_d.loe = mem_d && (!ph_d || wr_d);
    bus_d.lout = !bus_d.loe ? 8'h00 : (!ph_d ? mar_d[7:0] : wdat_d);
    if (st_d == S_IO) begin
      bus_d.io = 4'h1 << cnt_d;
      bus_d.io_in = (ir_d[7:4] == `TLC_IO_IN);
      if (cnt_d == 2'h0) begin
        bus_d.uab = {2'b00, ir_d[5:0]};
        bus_d.lout = cur.acc;
        bus_d.loe = 1'b1;
      end
    end
    bus_d.dma = (st_d == S_BOUND);
    bus_d.lv1 = (lvl_d == LV1);
    bus_d.lv2 = (lvl_d == LV2);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Sequencer state; reset starts on level 3 with both interrupts off.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= S_BOUND;  lvl_q <= LV3;  prev_q <= LV3;  ph_q <= 1'b0;
      en1_q <= 1'b0;  en2_q <= 1'b0;  aux_q <= 1'b0;
      mar_q <= 16'h0000;  ea_q <= 16'h0000;  ia_q <= 16'h0000;
      ir_q <= 8'h00;  wdat_q <= 8'h00;  sp_q <= `TLC_RESET_SP;
      ptr_q <= 8'h00;  cnt_q <= 2'h0;  bus_q <= '0;
    end else begin
      st_q <= st_d;  lvl_q <= lvl_d;  prev_q <= prev_d;  ph_q <= ph_d;
      en1_q <= en1_d;  en2_q <= en2_d;  aux_q <= aux_d;
      mar_q <= mar_d;  ea_q <= ea_d;  ia_q <= ia_d;
      ir_q <= ir_d;  wdat_q <= wdat_d;  sp_q <= sp_d;
      ptr_q <= ptr_d;  cnt_q <= cnt_d;  bus_q <= bus_d;
    end
  end

  // Outputs straight from the bus image flops.
  assign upper_address_bus    = bus_q.uab;
  assign lower_shared_bus_out = bus_q.lout;
  assign lower_shared_bus_oe  = bus_q.loe;
  assign addr_strobe          = bus_q.ale;
  assign mem_read             = bus_q.rd;
  assign mem_write            = bus_q.wr;
  assign io_strobe            = bus_q.io;
  assign io_input             = bus_q.io_in;
  assign dma_ready            = bus_q.dma;
  assign level_one_indicator  = bus_q.lv1;
  assign level_two_indicator  = bus_q.lv2;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_addr_range: assert property ((mem_read || addr_strobe) |->
    upper_address_bus[7] == 1'b0) else $error("Address above 32K.");
  a_level_excl: assert property (!(level_one_indicator &&
    level_two_indicator)) else $error("Both level outputs high.");
  a_mid_switch: assert property ((st_q == S_BOUND && !wait_req &&
    middle_priority_irq && en2_q && lvl_q == LV3 &&
    !(high_priority_irq && en1_q)) |=> level_two_indicator)
    else $error("Middle interrupt did not enter level two.");
  a_high_first: assert property ((st_q == S_BOUND && !wait_req &&
    high_priority_irq && en1_q) |=> level_one_indicator &&
    !level_two_indicator) else $error("High interrupt not taken.");
  a_io_order: assert property ((io_strobe == 4'h1) |=>
    io_strobe == 4'h2 ##1 io_strobe == 4'h4 ##1 io_strobe == 4'h8 ##1
    io_strobe == 4'h0) else $error("I/O strobes out of order.");
  a_io_first: assert property ((io_strobe == 4'h1) |->
    lower_shared_bus_oe && upper_address_bus[7:6] == 2'b00)
    else $error("First strobe without code and data.");
  a_wait_hold: assert property ((mem_read && wait_req) |=> mem_read &&
    $stable(upper_address_bus)) else $error("Cycle not held on wait.");
  a_push_step: assert property ((st_q == S_PUSH_LO && done) |=>
    sp_q == 8'($past(sp_q) + 8'h02)) else $error("Stack step wrong.");
  a_stack_page: assert property ((st_q inside {S_PUSH_HI, S_POP_LO}) |->
    mar_q[15:8] == 8'h00) else $error("Stack left page zero.");
  a_dma_after: assert property ((mem_write && !wait_req &&
    st_q == S_WR) |=> dma_ready) else $error("No DMA after last cycle.");
  a_aux_level3: assert property ((lvl_q != LV3) |=>
    $stable(aux_q)) else $error("Auxiliary link changed off level 3.");
endmodule

// File: tlc_regs.svh
// Constants of the three-level processor core: opcodes, resets, layout.
`ifndef TLC_REGS_SVH
`define TLC_REGS_SVH
`define TLC_RESET_PC    16'h0000
`define TLC_RESET_SP    8'h00
`define TLC_STACK_PAGE  8'h00
`define TLC_SP_STEP     8'h02
`define TLC_IO_LAST     2'h3
`define TLC_IO_CAPTURE  2'h2
`define TLC_F1_LDA      4'h0
`define TLC_F1_STA      4'h1
`define TLC_F1_ADD      4'h2
`define TLC_F1_AND      4'h3
`define TLC_F1_JMP      4'h4
`define TLC_F1_CALL     4'h5
`define TLC_F2_JMP      4'h4
`define TLC_F2_CALL     4'h5
`define TLC_F3_IMM      4'h6
`define TLC_F3_LDI      4'h0
`define TLC_IO_IN       4'h7
`define TLC_IO_OUT      4'h8
`define TLC_F6_ACCL     3'h5
`define TLC_F7_ON       6'h24
`define TLC_F7_OFF      6'h25
`define TLC_OP_RET      8'hc0
`define TLC_OP_ROT      8'hc1
`define TLC_OP_SWAP     8'hc2
`define TLC_OP_SKZ      8'hc3
`define TLC_OP_RETI     8'hc4
`define TLC_AL_CLA      5'h00
`define TLC_AL_CMA      5'h01
`define TLC_AL_CLL      5'h02
`define TLC_AL_CML      5'h03
`define TLC_AL_INC      5'h04
`endif

// File: tlc_pkg.sv
// Types shared by the three-level processor core.
package tlc_pkg;
  typedef enum logic [1:0] {LV1, LV2, LV3} tlc_level_t;
  typedef enum logic [2:0] {
    F_MEM, F_LONG, F_IMM, F_ONE, F_IO, F_ACCL, F_IRQ, F_NONE
  } tlc_fmt_t;
  typedef enum logic [3:0] {
    S_BOUND, S_FETCH, S_OPND2, S_IPTR_HI, S_IPTR_LO, S_EXEC, S_RD, S_WR,
    S_PUSH_HI, S_PUSH_LO, S_POP_HI, S_POP_LO, S_IO
  } tlc_state_t;
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  acc;
    logic        link;
  } tlc_ctx_t;
  typedef struct packed {
    tlc_fmt_t fmt;
    logic     ind;
    logic     cur_page;
    logic     io_in;
  } tlc_dec_t;
  typedef struct packed {
    logic [7:0] uab;
    logic [7:0] lout;
    logic       loe;
    logic       ale;
    logic       rd;
    logic       wr;
    logic [3:0] io;
    logic       io_in;
    logic       dma;
    logic       lv1;
    logic       lv2;
  } tlc_bus_t;
endpackage

// File: tlc_ctx_bank.sv
// One level's context: program counter, accumulator and main link.
`timescale 1ns/1ps
`include "tlc_regs.svh"
module tlc_ctx_bank (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             we,
  input  wire tlc_pkg::tlc_ctx_t d,
  output tlc_pkg::tlc_ctx_t     q
);
  import tlc_pkg::*;
  tlc_ctx_t q_q;
  tlc_ctx_t q_d;

  // Next value: load when this level is written.
  always_comb begin
    q_d = we ? d : q_q;
  end

  // Context register.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q_q <= '{pc: `TLC_RESET_PC, acc: 8'h00, link: 1'b0};
    end else begin
      q_q <= q_d;
    end
  end

  assign q = q_q;
endmodule

// File: tlc_decode.sv
// Instruction format decoder for the first byte of an instruction.
`timescale 1ns/1ps
`include "tlc_regs.svh"
module tlc_decode (
  input  wire logic [7:0]  ir,
  output tlc_pkg::tlc_dec_t dec
);
  import tlc_pkg::*;

  // Sort the byte into one of the seven formats, or F_NONE for bytes such as 0x98-0x9f.
  always_comb begin
    dec.fmt      = F_NONE;
    dec.ind      = ir[1];
    dec.cur_page = ir[0];
    dec.io_in    = (ir[7:4] == `TLC_IO_IN);
    if (ir[7:6] == 2'b00) begin
      dec.fmt = F_MEM;
    end else if (ir[7:4] == `TLC_F2_JMP || ir[7:4] == `TLC_F2_CALL) begin
      dec.fmt = F_LONG;
    end else if (ir[7:4] == `TLC_F3_IMM) begin
      dec.fmt = F_IMM;
    end else if (ir[7:4] == `TLC_IO_IN || ir[7:4] == `TLC_IO_OUT) begin
      dec.fmt = F_IO;
    end else if (ir[7:2] == `TLC_F7_ON || ir[7:2] == `TLC_F7_OFF) begin
      dec.fmt = F_IRQ;
    end else if (ir[7:5] == `TLC_F6_ACCL) begin
      dec.fmt = F_ACCL;
    end else if (ir[7:6] == 2'b11) begin
      dec.fmt = F_ONE;
    end
  end
endmodule

// File: tlc_mem_model.sv
// Behavioural program memory and peripheral on the core's buses.
`timescale 1ns/1ps
module tlc_mem_model #(
  parameter logic [7:0] PERIPH_DATA = 8'hc7
) (
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic       addr_strobe,
  input  wire logic       mem_read,
  input  wire logic       mem_write,
  input  wire logic [3:0] io_strobe,
  input  wire logic       io_input,
  input  wire logic [7:0] upper_address_bus,
  input  wire logic [7:0] core_out,
  output logic      [7:0] drive,
  output logic            stall
);
  logic [7:0]  mem [0:32767];
  logic [14:0] adr_q;
  logic        stalled_q = 1'b0;
  logic [7:0]  periph_q = 8'h00;
  logic [7:0]  last_q = 8'h00;
  logic [7:0]  io_code_q;
  logic [7:0]  io_data_q;
  int          io_ends = 0;

  // Slow mode stretches the first cycle of every read data phase.
  assign stall = slow && mem_read && !stalled_q;

  // Memory data, peripheral data, or a pattern that changes every cycle.
  always_comb begin
    if (mem_read)
      drive = mem[adr_q];
    else if (io_strobe[2])
      drive = periph_q;
    else
      drive = ~last_q;
  end

  // Address latch, writes and the peripheral's side of a transfer.
  always @(posedge ref_clk) begin
    last_q    <= drive;
    stalled_q <= mem_read;
    if (addr_strobe)
      adr_q <= {upper_address_bus[6:0], core_out};
    if (mem_write && !stall)
      mem[adr_q] <= core_out;
    if (io_strobe[0]) begin
      io_code_q <= upper_address_bus;
      io_data_q <= core_out;
    end
    if (io_strobe[1] && io_input)
      periph_q <= PERIPH_DATA;
    if (io_strobe[3]) begin
      periph_q <= 8'h00;
      io_ends  <= io_ends + 1;
    end
  end
endmodule

// File: triple_level_cpu_core_tb_top.sv
// Self-checking bench for the three-level processor core.
`timescale 1ns/1ps
module triple_level_cpu_core_tb_top;
  logic       ref_clk = 1'b0;
  logic       sys_rst, hold, slow, hi_irq, mid_irq, wait_req;
  logic [7:0] lower_shared_bus_in, lower_shared_bus_out, upper_address_bus;
  logic [7:0] drive;
  logic       lower_shared_bus_oe, addr_strobe, mem_read, mem_write;
  logic [3:0] io_strobe;
  logic       io_input, dma_ready, stall, lv1, lv2;
  logic       seen_ptr = 1'b0;
  logic [7:0] prog [0:14];
  int         fail_count = 0;
  int         checks_done = 0;

  // ---------------------------------------------------------------
  // Clock, bus wiring and instances
  // ---------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;
  assign lower_shared_bus_in = lower_shared_bus_oe ? lower_shared_bus_out
                                                   : drive;
  assign wait_req = stall | hold;

  tlc_core i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wait_req(wait_req),
    .high_priority_irq(hi_irq), .middle_priority_irq(mid_irq),
    .lower_shared_bus_in(lower_shared_bus_in),
    .lower_shared_bus_out(lower_shared_bus_out),
    .lower_shared_bus_oe(lower_shared_bus_oe),
    .upper_address_bus(upper_address_bus), .addr_strobe(addr_strobe),
    .mem_read(mem_read), .mem_write(mem_write), .io_strobe(io_strobe),
    .io_input(io_input), .dma_ready(dma_ready),
    .level_one_indicator(lv1), .level_two_indicator(lv2)
  );

  tlc_mem_model i_mem (
    .ref_clk(ref_clk), .slow(slow), .addr_strobe(addr_strobe),
    .mem_read(mem_read), .mem_write(mem_write), .io_strobe(io_strobe),
    .io_input(io_input), .upper_address_bus(upper_address_bus),
    .core_out(lower_shared_bus_out), .drive(drive), .stall(stall)
  );

  // Notes when the end of the pointer chain shows on the buses.
  always @(posedge ref_clk) begin
    if (addr_strobe && upper_address_bus == 8'h12 &&
        lower_shared_bus_out == 8'h34)
      seen_ptr <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_mem(input logic [14:0] a, input logic [7:0] exp);
    check_val({8'h00, i_mem.mem[a]}, {8'h00, exp});
  endtask

  task automatic summarize();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic step();
    @(posedge ref_clk);
    #2;
  endtask

  // Waits for level one (0), level two (1) or the stored input byte (2).
  task automatic wait_for(input int sel);
    for (int n = 0; n < 4000; n++) begin
      step();
      if ((sel == 0 && lv1 === 1'b1) || (sel == 1 && lv2 === 1'b1) ||
          (sel == 2 && i_mem.mem[15'h0043] === 8'hc7))
        return;
    end
    fail_count++;
    summarize();
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    hold    = 1'b0;
    slow    = 1'b1;
    hi_irq  = 1'b0;
    mid_irq = 1'b0;
    prog = '{8'h60, 8'h5a, 8'h04, 8'h40, 8'h03, 8'h80, 8'h04, 8'h41,
             8'h51, 8'h00, 8'h04, 8'h43, 8'h93, 8'h40, 8'h0d};
    for (int i = 0; i < 32768; i++)
      i_mem.mem[i] = 8'h00;
    for (int i = 0; i < 15; i++)
      i_mem.mem[i] = prog[i];
    {i_mem.mem[15'h0080], i_mem.mem[15'h0081]} = 16'h8090;
    {i_mem.mem[15'h0090], i_mem.mem[15'h0091]} = 16'h1234;
    i_mem.mem[15'h1234] = 8'ha5;
    // Subroutine: load, increment, rotate, swap, store to 0x44, then I/O.
    {i_mem.mem[15'h0100], i_mem.mem[15'h0101]} = 16'h603c;
    {i_mem.mem[15'h0102], i_mem.mem[15'h0103]} = 16'ha4c1;
    {i_mem.mem[15'h0104], i_mem.mem[15'h0105]} = 16'hc204;
    {i_mem.mem[15'h0106], i_mem.mem[15'h0107]} = 16'h4460;
    {i_mem.mem[15'h0108], i_mem.mem[15'h0109]} = 16'h3c8b;
    {i_mem.mem[15'h010a], i_mem.mem[15'h010b]} = 16'h71c0;
    repeat (16) @(posedge ref_clk);
    #2;
    check_val({lv1, lv2, dma_ready, addr_strobe}, 16'h0000);
    sys_rst = 1'b0;
    hold    = 1'b1;
    // Held wait keeps the core parked at the boundary with DMA offered.
    repeat (10) begin
      step();
      check_val({addr_strobe, dma_ready}, 16'h0001);
    end
    hold    = 1'b0;
    mid_irq = 1'b1;
    wait_for(1);
    check_val({upper_address_bus, lower_shared_bus_out}, 16'h0000);
    check_val({lv1, addr_strobe}, 16'h0001);
    chk_mem(15'h0040, 8'h5a);
    chk_mem(15'h0041, 8'ha5);
    check_val({15'h0000, seen_ptr}, 16'h0001);
    chk_mem(15'h0000, 8'h00);
    chk_mem(15'h0001, 8'h0a);
    chk_mem(15'h0043, 8'hc7);
    chk_mem(15'h0044, 8'ha7);
    check_val({i_mem.io_code_q, i_mem.io_data_q}, 16'h313c);
    check_val(16'(i_mem.io_ends), 16'h0002);
    // Level two reruns the program; a stale stack pair must be rewritten.
    slow = 1'b0;
    {i_mem.mem[15'h0000], i_mem.mem[15'h0001]} = 16'hffff;
    i_mem.mem[15'h0043] = 8'h00;
    wait_for(2);
    chk_mem(15'h0000, 8'h00);
    chk_mem(15'h0001, 8'h0a);
    hi_irq = 1'b1;
    wait_for(0);
    check_val({upper_address_bus, lower_shared_bus_out}, 16'h0000);
    check_val({lv2, addr_strobe}, 16'h0001);
    repeat (200) step();
    check_val({lv1, lv2}, 16'h0002);
    summarize();
  end
endmodule
